// File: src/ets_pkg.sv
// Purpose: Shared constants and layouts of the edge time stamp capture block.
// Assumes: A 125 MHz bus clock; the time stamp area is read over AHB-Lite.
// Notes:   Overview and bulleted behaviour list follow.
// Overview of operation
// - Entry input byte holds channel levels 0-3.
// - Input byte bits 4 to 7 read zero.
// - Sequence number counts 0 to 127, steps one.
// - Sequence numbers follow the order of edges.
// - Free-running 16-bit microsecond timer stamps entries.
// - Timer wraps to zero and keeps running.
// - Newest entry is written at offset zero.
// - Older entries shift four bytes toward higher offsets.
// - Sixteenth entry discards the oldest held entry.
// - Rising edges recorded only where rising enabled.
// - Falling edges recorded only where falling enabled.
// - Area holds fifteen four-byte entries, sixty bytes.
// - Entry order: input byte, sequence, time word.
package ets_pkg;

  // ----------------------------------------------------------------
  // Image geometry
  // ----------------------------------------------------------------
  localparam int         CHANNELS     = 4;
  localparam int         ENTRIES      = 15;
  localparam int         ENTRY_BYTES  = 4;
  localparam int         IMAGE_BYTES  = ENTRIES * ENTRY_BYTES;
  localparam logic [6:0] SEQ_MAX      = 7'h7f;
  localparam logic [3:0] COUNT_MAX    = 4'hf;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int         US_NS         = 1000;
  localparam int         CLK_PERIOD_NS = 8;
  localparam int         TICKS_PER_US  = US_NS / CLK_PERIOD_NS;
  localparam logic [6:0] PRESCALE_LAST = 7'(TICKS_PER_US - 1);

  // ----------------------------------------------------------------
  // Register map, word indices of byte address haddr[7:2]
  // ----------------------------------------------------------------
  localparam logic [7:0] IMAGE_OFFSET  = 8'h00;
  localparam logic [7:0] CTRL_OFFSET   = 8'h40;
  localparam logic [7:0] STATUS_OFFSET = 8'h44;
  localparam logic [7:0] TIMER_OFFSET  = 8'h48;
  localparam logic [5:0] CTRL_IDX      = CTRL_OFFSET[7:2];
  localparam logic [5:0] STATUS_IDX    = STATUS_OFFSET[7:2];
  localparam logic [5:0] TIMER_IDX     = TIMER_OFFSET[7:2];
  localparam logic [5:0] UNMAPPED_IDX  = 6'h3f;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         CTRL_RISE_LSB  = 0;
  localparam int         CTRL_FALL_LSB  = 4;
  localparam logic [3:0] RISE_EN_RESET  = 4'h0;
  localparam logic [3:0] FALL_EN_RESET  = 4'h0;
  localparam int         STAT_COUNT_LSB = 0;
  localparam int         STAT_SEQ_LSB   = 8;
  localparam int         STAT_OVF_BIT   = 16;
  localparam int         ENTRY_SEQ_LSB  = 8;
  localparam int         ENTRY_TIME_LSB = 16;
  localparam logic [2:0] SIZE_WORD      = 3'h2;

  // ----------------------------------------------------------------
  // Edge batch carried through the FIFO
  // ----------------------------------------------------------------
  localparam int BATCH_W        = 24;
  localparam int BATCH_MASK_LSB = 20;
  localparam int BATCH_LVL_LSB  = 16;
  localparam int FIFO_DEPTH     = 32;

endpackage

// File: src/entry_stream_if.sv
// Purpose: Valid/ready stream carrying edge batches between modules.
// Assumes: One clock domain.
// Notes:   Source drives valid and data, sink drives ready.
`timescale 1ns/1ps
`default_nettype none
interface entry_stream_if #(parameter int WIDTH = 24);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: src/entry_fifo.sv
// Purpose: Synchronous FIFO buffering edge batches.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Push and pop may happen in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module entry_fifo
  import ets_pkg::*;
#(
  parameter int WIDTH = BATCH_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic     hclk,
  input wire logic     hresetn,
  // Streams
  entry_stream_if.snk  push,
  entry_stream_if.src  pop
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic        do_push;
  logic        do_pop;

  assign push.ready = (st_reg.count != (AW+1)'(DEPTH));
  assign pop.valid  = (st_reg.count != '0);
  assign pop.data   = st_reg.mem[st_reg.rd_ptr];
  assign do_push    = push.valid & push.ready;
  assign do_pop     = pop.valid & pop.ready;

  always_comb
  begin
    st_next = st_reg;
    if (do_push)
    begin
      st_next.mem[st_reg.wr_ptr] = push.data;
      st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.wr_ptr + AW'(1);
    end
    if (do_pop)
    begin
      st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.rd_ptr + AW'(1);
    end
    if (do_push && !do_pop)
    begin
      st_next.count = st_reg.count + (AW+1)'(1);
    end
    else if (do_pop && !do_push)
    begin
      st_next.count = st_reg.count - (AW+1)'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule
`default_nettype wire

// File: src/edge_time_stamp_capture.sv
// Purpose: Time stamps enabled edges on four inputs into a 15-entry image.
// Assumes: AHB-Lite slave with zero wait states; inputs are asynchronous pins.
// Notes:   Edges seen in one cycle travel as one batch through the FIFO.
//
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module edge_time_stamp_capture
  import ets_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Digital input pins
  input  wire logic [3:0]  input_channel
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]               sync_a;
    logic [3:0]               sync_b;
    logic [3:0]               prev;
    logic [6:0]               prescale;
    logic [15:0]              timer_us;
    logic [3:0]               rise_en;
    logic [3:0]               fall_en;
    logic                     overflow;
    logic                     wr_pend;
    logic [5:0]               wr_idx;
    logic [31:0]              rd_data;
    logic [3:0]               spread_mask;
    logic [3:0]               spread_levels;
    logic [15:0]              spread_time;
    logic [6:0]               seq;
    logic [3:0]               count;
    logic [ENTRIES-1:0][31:0] image;
  } ets_state_t;

  localparam ets_state_t STATE_RESET = '{
    sync_a:        4'h0,
    sync_b:        4'h0,
    prev:          4'h0,
    prescale:      7'h00,
    timer_us:      16'h0000,
    rise_en:       RISE_EN_RESET,
    fall_en:       FALL_EN_RESET,
    overflow:      1'b0,
    wr_pend:       1'b0,
    wr_idx:        6'h00,
    rd_data:       32'h0000_0000,
    spread_mask:   4'h0,
    spread_levels: 4'h0,
    spread_time:   16'h0000,
    seq:           7'h00,
    count:         4'h0,
    image:         '0
  };

  ets_state_t st_reg;
  ets_state_t st_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Word index of a bus address; anything outside the low page is unmapped.
  function automatic logic [5:0] reg_index(input logic [31:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    if (addr[31:8] != 24'h000000)
    begin
      idx = UNMAPPED_IDX;
    end
    return idx;
  endfunction

  // Lowest set bit of a channel mask, as a one-hot value.
  function automatic logic [3:0] lowest_onehot(input logic [3:0] m);
    return m & (~m + 4'h1);
  endfunction

  // Packs one image entry in its byte order.
  function automatic logic [31:0] pack_entry(
    input logic [3:0]  levels,
    input logic [6:0]  seq,
    input logic [15:0] time_us
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[3:0] = levels;
    w[7:4] = 4'h0;
    w[ENTRY_SEQ_LSB +: 8] = {1'b0, seq};
    w[ENTRY_TIME_LSB +: 16] = time_us;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Batch FIFO
  // ----------------------------------------------------------------
  entry_stream_if #(.WIDTH(BATCH_W)) push_bus ();
  entry_stream_if #(.WIDTH(BATCH_W)) pop_bus ();

  entry_fifo #(
    .WIDTH (BATCH_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .hclk    (hclk),
    .hresetn (hresetn),
    .push    (push_bus),
    .pop     (pop_bus)
  );

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic [3:0] rise_hit;
  logic [3:0] fall_hit;
  logic [3:0] edge_hit;

  assign rise_hit = st_reg.sync_b & ~st_reg.prev & st_reg.rise_en;
  assign fall_hit = ~st_reg.sync_b & st_reg.prev & st_reg.fall_en;
  assign edge_hit = rise_hit | fall_hit;

  // All edges of a cycle share one batch and one time value.
  assign push_bus.valid = (edge_hit != 4'h0);
  assign push_bus.data  = {edge_hit, st_reg.sync_b, st_reg.timer_us};

  // A new batch is taken only once the previous one is spread out.
  assign pop_bus.ready  = (st_reg.spread_mask == 4'h0);

  // ----------------------------------------------------------------
  // Bus outputs
  // ----------------------------------------------------------------
  logic        bus_taken;
  logic [5:0]  bus_idx;
  logic [31:0] rd_word;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_reg.rd_data;
  assign bus_taken = hsel & htrans[1] & hready;
  assign bus_idx   = reg_index(haddr);

  // Read multiplexer; empty image slots read zero.
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (bus_idx < 6'(ENTRIES))
    begin
      rd_word = st_reg.image[bus_idx[3:0]];
    end
    else if (bus_idx == CTRL_IDX)
    begin
      rd_word[CTRL_RISE_LSB +: 4] = st_reg.rise_en;
      rd_word[CTRL_FALL_LSB +: 4] = st_reg.fall_en;
    end
    else if (bus_idx == STATUS_IDX)
    begin
      rd_word[STAT_COUNT_LSB +: 4] = st_reg.count;
      rd_word[STAT_SEQ_LSB +: 7] = st_reg.seq;
      rd_word[STAT_OVF_BIT] = st_reg.overflow;
    end
    else if (bus_idx == TIMER_IDX)
    begin
      rd_word[15:0] = st_reg.timer_us;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [3:0]  pick;
  logic [31:0] new_entry;

  assign pick      = lowest_onehot(st_reg.spread_mask);
  assign new_entry = pack_entry(st_reg.spread_levels, st_reg.seq, st_reg.spread_time);

  always_comb
  begin
    st_next = st_reg;

    // Two-flop synchroniser, then one stage for edge detection.
    st_next.sync_a = input_channel;
    st_next.sync_b = st_reg.sync_a;
    st_next.prev   = st_reg.sync_b;

    // Microsecond timebase, free running from reset.
    if (st_reg.prescale == PRESCALE_LAST)
    begin
      st_next.prescale = 7'h00;
      st_next.timer_us = st_reg.timer_us + 16'h0001;
    end
    else
    begin
      st_next.prescale = st_reg.prescale + 7'h01;
    end

    // Spread a batch, one entry per cycle, lowest channel first.
    if (st_reg.spread_mask != 4'h0)
    begin
      st_next.spread_mask = st_reg.spread_mask & ~pick;
      for (int i = ENTRIES - 1; i > 0; i--)
      begin
        st_next.image[i] = st_reg.image[i-1];
      end
      st_next.image[0] = new_entry;
      if (st_reg.seq == SEQ_MAX)
      begin
        st_next.seq = 7'h00;
      end
      else
      begin
        st_next.seq = st_reg.seq + 7'h01;
      end
      if (st_reg.count != COUNT_MAX)
      begin
        st_next.count = st_reg.count + 4'h1;
      end
    end

    // Load the next batch in arrival order.
    if (pop_bus.valid && pop_bus.ready)
    begin
      st_next.spread_mask   = pop_bus.data[BATCH_MASK_LSB +: 4];
      st_next.spread_levels = pop_bus.data[BATCH_LVL_LSB +: 4];
      st_next.spread_time   = pop_bus.data[15:0];
    end

    // Data phase of a register write.
    if (st_reg.wr_pend)
    begin
      if (st_reg.wr_idx == CTRL_IDX)
      begin
        st_next.rise_en = hwdata[CTRL_RISE_LSB +: 4];
        st_next.fall_en = hwdata[CTRL_FALL_LSB +: 4];
      end
      else if (st_reg.wr_idx == STATUS_IDX && hwdata[STAT_OVF_BIT])
      begin
        st_next.overflow = 1'b0;
      end
    end

    // A batch refused by a full FIFO is lost; the flag records it.
    if (push_bus.valid && !push_bus.ready)
    begin
      st_next.overflow = 1'b1;
    end

    // Address phase of a bus transfer.
    st_next.wr_pend = bus_taken & hwrite & (hsize == SIZE_WORD);
    st_next.wr_idx  = bus_idx;
    if (bus_taken && !hwrite)
    begin
      st_next.rd_data = rd_word;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= STATE_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule
`default_nettype wire

// File: tb/edge_time_stamp_capture_chk.sv
// Purpose: Port-level property checks of the edge time stamp block.
// Assumes: Zero-wait bus slave, one clock, asynchronous active-low reset.
// Notes:   Bound to the top module from the bench file.
`timescale 1ns/1ps
`default_nettype none
module edge_time_stamp_capture_chk
  import ets_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Pins
  input wire logic [3:0]  input_channel
);
  logic        rd_q;
  logic        wr_q;
  logic [31:0] a_q;
  logic [7:0]  ctrl_s;
  logic [7:0]  ctrl_e;
  logic [15:0] t_prev;
  logic [31:0] since;
  logic [15:0] t_gap;
  logic        take;
  logic        t_rd;
  logic        img_rd;
  assign take   = hsel && htrans[1] && hready;
  assign t_rd   = rd_q && a_q == 32'(TIMER_OFFSET);
  assign img_rd = rd_q && a_q < 32'h3c;
  assign t_gap  = hrdata[15:0] - t_prev;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Follows data phases and mirrors the enable word as it stood at each read.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      a_q    <= 32'h0;
      ctrl_s <= 8'h0;
      ctrl_e <= 8'h0;
      t_prev <= 16'h0;
      since  <= 32'h0;
    end
    else
    begin
      rd_q   <= take && !hwrite;
      wr_q   <= take && hwrite && hsize == SIZE_WORD;
      a_q    <= haddr;
      since  <= t_rd ? 32'h1 : since + 32'h1;
      t_prev <= t_rd ? hrdata[15:0] : t_prev;
      ctrl_s <= (wr_q && a_q == 32'(CTRL_OFFSET)) ? hwdata[7:0] : ctrl_s;
      ctrl_e <= (take && !hwrite) ? ctrl_s : ctrl_e;
    end
  a_ready_high: assert property (hreadyout)
    else $error("bus slave inserted a wait state");
  a_resp_okay: assert property (!hresp)
    else $error("bus slave gave an error response");
  a_reserved_zero: assert property (img_rd |-> hrdata[7:4] == 4'h0)
    else $error("reserved input bits not zero");
  a_seq_width: assert property (img_rd |-> !hrdata[15])
    else $error("sequence number above 127");
  a_gap_zero: assert property (rd_q && (a_q == 32'h3c || a_q[31:8] != 24'h0)
    |-> hrdata == 32'h0)
    else $error("read outside the map not zero");
  a_rdata_hold: assert property (!rd_q |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_timer_width: assert property (t_rd |-> hrdata[31:16] == 16'h0)
    else $error("timer wider than 16 bits");
  a_timer_pace: assert property (t_rd |-> 32'(t_gap) * 32'd125 <= since + 32'd250
    && 32'(t_gap) * 32'd125 + 32'd250 >= since)
    else $error("timer does not advance once per microsecond");
  a_ctrl_echo: assert property (rd_q && a_q == 32'(CTRL_OFFSET)
    |-> hrdata[7:0] == ctrl_e)
    else $error("edge enables read back wrong");
endmodule
`default_nettype wire

// File: tb/field_sensor_model.sv
// Purpose: Field sensors driving the four digital inputs.
// Assumes: Push-pull sensors, so a pin always shows a firm level.
// Notes:   The slow mode delays each change by one more clock.
`timescale 1ns/1ps
`default_nettype none
module field_sensor_model
(
  // Clock
  input  wire logic       hclk,
  // Requested levels and speed
  input  wire logic [3:0] level_cmd,
  input  wire logic       slow,
  // Pins
  output logic      [3:0] input_channel
);
  logic [3:0] stage;
  always @(posedge hclk)
  begin
    stage         <= level_cmd;
    input_channel <= slow ? stage : level_cmd;
  end
endmodule
`default_nettype wire

// File: tb/test_edge_time_stamp_capture.sv
// Purpose: Self-checking bench for the edge time stamp block.
// Assumes: Zero-wait bus slave; the sensor model drives the pins.
// Notes:   Reads queue their expectation; a monitor compares them.
`timescale 1ns/1ps
`default_nettype none
module test_edge_time_stamp_capture
  import ets_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = SIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [3:0]  input_channel;
  logic [3:0]  level_cmd = 4'h0;
  logic        slow = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [15:0] img[$];
  logic [6:0]  seq = 7'h0;
  logic [7:0]  ctrl = 8'h0;
  logic [3:0]  cur = 4'h0;
  logic        rd_dp = 1'b0;
  logic [31:0] rv;
  int          fail_count = 0;
  int          tests_run = 0;
  assign hready = hreadyout;
  always #4 hclk = ~hclk;
  edge_time_stamp_capture edge_time_stamp_capture_inst (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .input_channel);
  field_sensor_model field_sensor_model_inst (.hclk, .level_cmd, .slow, .input_channel);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    if (n >= 64)
    begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w)
    begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    wait_rdy();
    rv = hrdata;
  endtask
  // Moves the pins and notes the entries that the enabled edges must make.
  task automatic apply(input logic [3:0] v);
    for (int c = 0; c < 4; c++)
      if ((!cur[c] && v[c] && ctrl[c]) || (cur[c] && !v[c] && ctrl[c+4]))
      begin
        img.push_front({1'b0, seq, 4'h0, v});
        seq++;
        if (img.size() > 15)
          void'(img.pop_back());
      end
    cur = v;
    @(posedge hclk);
    level_cmd <= v;
    repeat (14) @(posedge hclk);
  endtask
  task automatic verify();
    for (int i = 0; i < 15; i++)
      bus(1'b0, 32'(4 * i), 32'h0, (i < img.size()) ? 32'(img[i]) : 32'h0, 32'hffff);
    bus(1'b0, 32'(STATUS_OFFSET), 32'h0, {17'h0, seq, 4'h0, 4'(img.size())}, 32'h1_7f0f);
  endtask
  always @(posedge hclk)
  begin
    if (rd_dp && hready === 1'b1)
    begin
      tests_run++;
      if (((hrdata ^ exp_q[0]) & msk_q[0]) !== 32'h0)
      begin
        fail_count++;
        $display("mismatch at %0t: got %h exp %h", $time, hrdata, exp_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    if (hready === 1'b1)
      rd_dp = hsel && htrans[1] && !hwrite && hresetn;
  end
  initial
  begin
    void'($urandom(32'hb262));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'(CTRL_OFFSET), 32'h0, 32'h0, 32'hff);
    bus(1'b0, 32'h3c, 32'h0, 32'h0, 32'hffffffff);
    bus(1'b0, 32'h100, 32'h0, 32'h0, 32'hffffffff);
    verify();
    ctrl = 8'h33;
    bus(1'b1, 32'(CTRL_OFFSET), 32'h33, 32'h0, 32'h0);
    bus(1'b0, 32'(CTRL_OFFSET), 32'h0, 32'h33, 32'hff);
    apply(4'h1);
    apply(4'h3);
    apply(4'h2);
    apply(4'he);
    apply(4'h2);
    bus(1'b1, 32'h0, 32'hffffffff, 32'h0, 32'h0);
    verify();
    ctrl = 8'hff;
    bus(1'b1, 32'(CTRL_OFFSET), 32'hff, 32'h0, 32'h0);
    apply(4'h0);
    apply(4'h3);
    bus(1'b0, 32'h0, 32'h0, 32'(img[0]), 32'hffff);
    bus(1'b0, 32'h4, 32'h0, {rv[31:16], img[1]}, 32'hffffffff);
    for (int i = 0; i < 150; i++)
    begin
      if (i % 50 == 25)
      begin
        ctrl = 8'($urandom);
        bus(1'b1, 32'(CTRL_OFFSET), 32'(ctrl), 32'h0, 32'h0);
      end
      slow <= 1'($urandom);
      apply(4'($urandom));
      if (i % 30 == 29)
        verify();
    end
    bus(1'b0, 32'(TIMER_OFFSET), 32'h0, 32'h0, 32'hffff0000);
    repeat (1250) @(posedge hclk);
    bus(1'b0, 32'(TIMER_OFFSET), 32'h0, 32'h0, 32'hffff0000);
    verify();
    conclude();
  end
endmodule
bind edge_time_stamp_capture edge_time_stamp_capture_chk edge_time_stamp_capture_chk_inst (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .hreadyout, .hresp, .hrdata, .input_channel);
`default_nettype wire
